// ==== rtl/fsc_pkg.sv ====
// Purpose: shared constants, field layouts and types of the flash status/config bank
// Assumes: one 100 MHz core clock; commands arrive already decoded
// Notes:   first data byte of a register write sits in data[15:8]
package fsc_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned WRITE_CYCLE_NS   = 10000;      // plain default, no figure known

	// ****************************************
	// status field positions
	// ****************************************
	localparam int unsigned ST_WIP_BIT       = 0;
	localparam int unsigned ST_WEL_BIT       = 1;
	localparam int unsigned ST_LEVEL_LSB     = 2;
	localparam int unsigned ST_LEVEL_MSB     = 5;
	localparam int unsigned ST_QUAD_BIT      = 6;
	localparam int unsigned ST_LOCK_BIT      = 7;

	// ****************************************
	// configuration field positions
	// ****************************************
	localparam int unsigned CF_DRIVE_LSB     = 0;
	localparam int unsigned CF_DRIVE_MSB     = 2;
	localparam int unsigned CF_BOTTOM_BIT    = 3;
	localparam int unsigned CF_PREAMBLE_BIT  = 4;
	localparam int unsigned CF_WIDE_BIT      = 5;
	localparam int unsigned CF_DUMMY_LSB     = 6;
	localparam int unsigned CF_DUMMY_MSB     = 7;

	// ****************************************
	// reset values and lengths
	// ****************************************
	localparam logic [3:0]  LEVEL_RESET      = 4'h0;
	localparam logic [2:0]  DRIVE_RESET      = 3'h7;       // 30 ohm code
	localparam logic [1:0]  DUMMY_RESET      = 2'h0;
	localparam logic [4:0]  BITS_STATUS_ONLY = 5'h08;
	localparam logic [4:0]  BITS_BOTH_REGS   = 5'h10;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		FSC_CMD_WRITE_ENABLE,
		FSC_CMD_WRITE_DISABLE,
		FSC_CMD_WRITE_REGS,
		FSC_CMD_ENTER_WIDE,
		FSC_CMD_EXIT_WIDE,
		FSC_CMD_PAGE_PROGRAM,
		FSC_CMD_SECTOR_ERASE,
		FSC_CMD_HALF_BLOCK_ERASE,
		FSC_CMD_BLOCK_ERASE,
		FSC_CMD_CHIP_ERASE
	} fsc_cmd_t;

	typedef struct packed {
		logic        valid;            // one-cycle pulse at chip-select rise
		fsc_cmd_t    cmd;
		logic [4:0]  data_bits;        // data bits clocked after the opcode
		logic [15:0] data;             // first byte in [15:8]
		logic        target_protected; // from the protected-area decoder
	} fsc_req_t;

	typedef struct packed {
		logic        start;            // one-cycle pulse to the array engine
		fsc_cmd_t    cmd;
	} fsc_op_t;

endpackage : fsc_pkg

// ==== rtl/fsc_cycle_timer.sv ====
// Purpose: self-timed interval counter for the register write cycle
// Assumes: start is a one-cycle pulse while idle
// Notes:   done pulses once when the count expires
module fsc_cycle_timer #(
	parameter int unsigned CYCLES = 1000
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	logic [31:0] count;

	// ****************************************
	// countdown
	// ****************************************
	// a start while busy is ignored, the caller never issues one
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 32'h0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (busy) begin
				if (count == 32'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 32'h1;
				end
			end else if (start) begin
				busy  <= 1'b1;
				count <= LAST;
			end
		end
	end

endmodule : fsc_cycle_timer

// ==== rtl/fsc_regs.sv ====
// Purpose: status and configuration registers of a serial flash, with protection checks
// Assumes: decoded commands on core_clk; pins write_protect_n and hard_reset_n are async
// Notes:   non-volatile bits are flops reset to factory values on power-up reset only

// Overview of operation
// - busy flag set during program, erase or register write, else cleared.
// - write latch must be set before program, erase or register write.
// - program or erase aimed at a protected area is ignored.
// - four protect level bits, default zero, changed only by register write.
// - protect level blocks program and all erase commands in its area.
// - chip erase runs only with protect level zero.
// - quad enable disables write-protect and reset pin functions.
// - lock set with write-protect low refuses register write.
// - lock bit is non-volatile, default zero.
// - drive strength field volatile, default 30 ohm code, register write sets it.
// - bottom-protect bit one-time programmable, default top.
// - preamble enable volatile, default off, set by register write.
// - wide address bit set by enter, cleared by exit, reset pin or power-off.
// - dummy cycle select two bits, default zero.
// - register write keeps busy for self-timed interval, then clears busy and latch.
// - register write valid only with exactly 8 or 16 data bits.
module fsc_regs #(
	parameter int unsigned WRITE_CYCLE_NS = fsc_pkg::WRITE_CYCLE_NS
) (
	input  wire logic            core_clk,
	input  wire logic            rst_b,
	input  wire logic            write_protect_n,
	input  wire logic            hard_reset_n,
	input  wire fsc_pkg::fsc_req_t req,
	input  wire logic            op_done,
	output logic [7:0]           flash_status,
	output logic [7:0]           flash_configuration,
	output logic                 hw_protect_state,
	output logic                 quad_io_enable,
	output fsc_pkg::fsc_op_t     op,
	output logic                 refused
);

	// least time, round up
	localparam int unsigned WRITE_CYCLES =
		(WRITE_CYCLE_NS + fsc_pkg::CLK_PERIOD_NS - 1) / fsc_pkg::CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		FSC_IDLE,
		FSC_REG_WRITE,
		FSC_ARRAY_OP
	} fsc_state_t;

	fsc_state_t  state;
	logic        write_in_progress;
	logic        write_latch_flag;
	logic [3:0]  protect_level;
	logic        status_lock;
	logic [2:0]  drive_strength_sel;
	logic        protect_from_bottom;
	logic        preamble_enable;
	logic        wide_address_mode;
	logic [1:0]  dummy_cycle_sel;
	logic [1:0]  wp_sync;
	logic [1:0]  rst_sync;
	logic        timer_start;
	logic        timer_done;
	logic        pin_reset;
	logic        is_array_cmd;
	logic        accept_regs;
	logic        accept_array;

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_sync  <= 2'h3;
			rst_sync <= 2'h3;
		end else begin
			wp_sync  <= {wp_sync[0], write_protect_n};
			rst_sync <= {rst_sync[0], hard_reset_n};
		end
	end

	// ****************************************
	// command qualification
	// ****************************************
	// reset pin only acts while quad mode is off
	assign pin_reset    = !rst_sync[1] && !quad_io_enable;
	assign is_array_cmd = req.cmd inside {fsc_pkg::FSC_CMD_PAGE_PROGRAM,
	                                      fsc_pkg::FSC_CMD_SECTOR_ERASE,
	                                      fsc_pkg::FSC_CMD_HALF_BLOCK_ERASE,
	                                      fsc_pkg::FSC_CMD_BLOCK_ERASE,
	                                      fsc_pkg::FSC_CMD_CHIP_ERASE};
	assign accept_regs  = req.valid && req.cmd == fsc_pkg::FSC_CMD_WRITE_REGS
	                   && state == FSC_IDLE && write_latch_flag
	                   && !hw_protect_state
	                   && (req.data_bits == fsc_pkg::BITS_STATUS_ONLY
	                    || req.data_bits == fsc_pkg::BITS_BOTH_REGS);
	assign accept_array = req.valid && is_array_cmd && state == FSC_IDLE
	                   && write_latch_flag
	                   && !req.target_protected
	                   && (req.cmd != fsc_pkg::FSC_CMD_CHIP_ERASE
	                    || protect_level == fsc_pkg::LEVEL_RESET);
	assign timer_start  = accept_regs;

	// ****************************************
	// self-timed register write interval
	// ****************************************
	fsc_cycle_timer #(
		.CYCLES (WRITE_CYCLES)
	) u_timer (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.start    (timer_start),
		.busy     (),
		.done     (timer_done)
	);

	// ****************************************
	// cycle sequencing and busy flag
	// ****************************************
	// busy rises the cycle after acceptance so a status read then sees it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state             <= FSC_IDLE;
			write_in_progress <= 1'b0;
		end else begin
			case (state)
				FSC_IDLE: begin
					if (accept_regs) begin
						state             <= FSC_REG_WRITE;
						write_in_progress <= 1'b1;
					end else if (accept_array) begin
						state             <= FSC_ARRAY_OP;
						write_in_progress <= 1'b1;
					end
				end
				FSC_REG_WRITE: begin
					if (timer_done) begin
						state             <= FSC_IDLE;
						write_in_progress <= 1'b0;
					end
				end
				FSC_ARRAY_OP: begin
					if (op_done) begin
						state             <= FSC_IDLE;
						write_in_progress <= 1'b0;
					end
				end
				default: begin
					state             <= FSC_IDLE;
					write_in_progress <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// write latch
	// ****************************************
	// completion clear wins over a same-cycle enable, which the busy check refuses anyway
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			write_latch_flag <= 1'b0;
		end else if (pin_reset) begin
			write_latch_flag <= 1'b0;
		end else if ((state == FSC_REG_WRITE && timer_done)
		          || (state == FSC_ARRAY_OP && op_done)) begin
			write_latch_flag <= 1'b0;
		end else if (req.valid && state == FSC_IDLE) begin
			if (req.cmd == fsc_pkg::FSC_CMD_WRITE_ENABLE) begin
				write_latch_flag <= 1'b1;
			end else if (req.cmd == fsc_pkg::FSC_CMD_WRITE_DISABLE) begin
				write_latch_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// non-volatile status bits
	// ****************************************
	// survive the reset pin; only power-up reset restores factory values
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			protect_level  <= fsc_pkg::LEVEL_RESET;
			quad_io_enable <= 1'b0;
			status_lock    <= 1'b0;
		end else if (accept_regs) begin
			protect_level  <= req.data[8 + fsc_pkg::ST_LEVEL_MSB :
			                           8 + fsc_pkg::ST_LEVEL_LSB];
			quad_io_enable <= req.data[8 + fsc_pkg::ST_QUAD_BIT];
			status_lock    <= req.data[8 + fsc_pkg::ST_LOCK_BIT];
		end
	end

	// ****************************************
	// configuration bits
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_strength_sel  <= fsc_pkg::DRIVE_RESET;
			protect_from_bottom <= 1'b0;
			preamble_enable     <= 1'b0;
			dummy_cycle_sel     <= fsc_pkg::DUMMY_RESET;
		end else if (pin_reset) begin
			drive_strength_sel  <= fsc_pkg::DRIVE_RESET;
			preamble_enable     <= 1'b0;
			dummy_cycle_sel     <= fsc_pkg::DUMMY_RESET;
		end else if (accept_regs && req.data_bits == fsc_pkg::BITS_BOTH_REGS) begin
			drive_strength_sel  <= req.data[fsc_pkg::CF_DRIVE_MSB :
			                                fsc_pkg::CF_DRIVE_LSB];
			// one-time programmable: a register write can set it, never clear it
			protect_from_bottom <= protect_from_bottom
			                     | req.data[fsc_pkg::CF_BOTTOM_BIT];
			preamble_enable     <= req.data[fsc_pkg::CF_PREAMBLE_BIT];
			dummy_cycle_sel     <= req.data[fsc_pkg::CF_DUMMY_MSB :
			                                fsc_pkg::CF_DUMMY_LSB];
		end
	end

	// ****************************************
	// wide address indicator
	// ****************************************
	// ignored while busy, like every other state-changing command, without raising refused
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wide_address_mode <= 1'b0;
		end else if (pin_reset) begin
			wide_address_mode <= 1'b0;
		end else if (req.valid && state == FSC_IDLE) begin
			if (req.cmd == fsc_pkg::FSC_CMD_ENTER_WIDE) begin
				wide_address_mode <= 1'b1;
			end else if (req.cmd == fsc_pkg::FSC_CMD_EXIT_WIDE) begin
				wide_address_mode <= 1'b0;
			end
		end
	end

	// ****************************************
	// protection state and engine handshake
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hw_protect_state <= 1'b0;
			op               <= '{start: 1'b0, cmd: fsc_pkg::FSC_CMD_WRITE_ENABLE};
			refused          <= 1'b0;
		end else begin
			hw_protect_state <= status_lock && !wp_sync[1] && !quad_io_enable;
			op.start         <= accept_array;
			if (accept_array) begin
				op.cmd <= req.cmd;
			end
			refused          <= req.valid && !accept_regs && !accept_array
			                 && (is_array_cmd || req.cmd == fsc_pkg::FSC_CMD_WRITE_REGS);
		end
	end

	// ****************************************
	// register images, wiring of flops only
	// ****************************************
	assign flash_status = {status_lock, quad_io_enable, protect_level,
	                       write_latch_flag, write_in_progress};
	assign flash_configuration = {dummy_cycle_sel, wide_address_mode, preamble_enable,
	                              protect_from_bottom, drive_strength_sel};

endmodule : fsc_regs

// ==== tb/fsc_regs_checker.sv ====
// Purpose: port-level checks of the status/config bank
// Assumes: one clock, async active-low reset
// Notes:   bound to every fsc_regs instance
module fsc_regs_checker #(
	parameter int unsigned WRITE_CYCLE_NS = 100
) (
	input wire logic              core_clk,
	input wire logic              rst_b,
	input wire fsc_pkg::fsc_req_t req,
	input wire logic              op_done,
	input wire logic [7:0]        flash_status,
	input wire logic [7:0]        flash_configuration,
	input wire logic              hw_protect_state,
	input wire logic              quad_io_enable,
	input wire fsc_pkg::fsc_op_t  op,
	input wire logic              refused
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// ****************************************
	// request shapes
	// ****************************************
	sequence s_take;
		req.valid && !flash_status[0];
	endsequence
	sequence s_array;
		s_take ##0 req.cmd >= fsc_pkg::FSC_CMD_PAGE_PROGRAM;
	endsequence
	sequence s_wregs;
		s_take ##0 req.cmd == fsc_pkg::FSC_CMD_WRITE_REGS;
	endsequence

	// ****************************************
	// properties
	// ****************************************
	property p_latch;
		s_array ##0 !flash_status[1] |=> refused && !op.start;
	endproperty
	property p_prot;
		s_array ##0 req.target_protected |=> refused && !op.start;
	endproperty
	property p_chip;
		s_array ##0 req.cmd == fsc_pkg::FSC_CMD_CHIP_ERASE && flash_status[5:2] != 4'h0
			|=> refused && !op.start;
	endproperty
	property p_hwlock;
		s_wregs ##0 hw_protect_state |=> refused && $stable(flash_status[7:2]);
	endproperty
	property p_count;
		s_wregs ##0 req.data_bits != 5'h08 && req.data_bits != 5'h10 |=> refused;
	endproperty
	property p_busy;
		op.start |-> flash_status[0];
	endproperty
	property p_done;
		op_done && flash_status[0] |=> !flash_status[0];
	endproperty
	property p_fall;
		$fell(flash_status[0]) |-> !flash_status[1];
	endproperty
	property p_wide;
		s_take ##0 req.cmd == fsc_pkg::FSC_CMD_ENTER_WIDE |=> flash_configuration[5];
	endproperty
	// hw state is registered, so compare with the previous lock and quad
	property p_hw;
		hw_protect_state |-> $past(flash_status[7] && !quad_io_enable);
	endproperty

	a_latch: assert property (p_latch) else $error("array cmd taken without latch");
	a_prot: assert property (p_prot) else $error("protected target taken");
	a_chip: assert property (p_chip) else $error("chip erase with level set");
	a_hwlock: assert property (p_hwlock) else $error("write under hw lock");
	a_count: assert property (p_count) else $error("bad bit count taken");
	a_busy: assert property (p_busy) else $error("start without busy");
	a_done: assert property (p_done) else $error("busy stays after done");
	a_fall: assert property (p_fall) else $error("latch left after cycle");
	a_wide: assert property (p_wide) else $error("wide bit not set");
	a_hw: assert property (p_hw) else $error("hw state without cause");
endmodule : fsc_regs_checker

bind fsc_regs fsc_regs_checker #(.WRITE_CYCLE_NS(WRITE_CYCLE_NS)) i_chk (.core_clk, .rst_b,
	.req, .op_done, .flash_status, .flash_configuration, .hw_protect_state, .quad_io_enable,
	.op, .refused);

// ==== tb/fsc_engine_model.sv ====
// Purpose: array engine stand-in answering accepted program/erase starts
// Assumes: op.start is a one-cycle pulse
// Notes:   fixed short latency; a real engine takes far longer
module fsc_engine_model #(
	parameter int unsigned LATENCY = 5
) (
	input wire logic             core_clk,
	input wire logic             rst_b,
	input wire fsc_pkg::fsc_op_t op,
	output logic                 op_done
);
	int unsigned left;

	// count down from each start, then pulse done once
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			left    <= 0;
			op_done <= 1'h0;
		end else begin
			op_done <= (left == 1);
			if (op.start) begin
				left <= LATENCY;
			end else if (left != 0) begin
				left <= left - 1;
			end
		end
	end
endmodule : fsc_engine_model

// ==== tb/flash_status_config_regs_test.sv ====
// Purpose: directed scenarios for the status/config bank
// Assumes: 10-cycle write interval (WRITE_CYCLE_NS 100)
// Notes:   inputs change on falling edges only
module flash_status_config_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk;
	logic              rst_b;
	logic              write_protect_n;
	logic              hard_reset_n;
	fsc_pkg::fsc_req_t req;
	logic              op_done;
	logic [7:0]        flash_status;
	logic [7:0]        flash_configuration;
	logic              hw_protect_state;
	logic              quad_io_enable;
	fsc_pkg::fsc_op_t  op;
	logic              refused;
	int                fails;
	int                checks_done;

	fsc_regs #(.WRITE_CYCLE_NS(100)) i_dut (.core_clk, .rst_b, .write_protect_n,
		.hard_reset_n, .req, .op_done, .flash_status, .flash_configuration,
		.hw_protect_state, .quad_io_enable, .op, .refused);
	fsc_engine_model i_eng (.core_clk, .rst_b, .op, .op_done);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	// one request pulse; the registered answers are settled on return
	task automatic send(input fsc_pkg::fsc_cmd_t c, input logic [4:0] n, input logic [15:0] d,
		input logic p);
		@(negedge core_clk);
		req <= '{1'h1, c, n, d, p};
		@(negedge core_clk);
		req.valid <= 1'h0;
	endtask : send
	task automatic wregs(input logic [4:0] n, input logic [15:0] d);
		send(fsc_pkg::FSC_CMD_WRITE_ENABLE, 5'h00, 16'h0000, 1'h0);
		send(fsc_pkg::FSC_CMD_WRITE_REGS, n, d, 1'h0);
	endtask : wregs
	// bounded poll, as a host would before the next operation
	task automatic wait_idle;
		int k;
		k = 0;
		while (flash_status[0] !== 1'h0 && k < 300) begin
			@(negedge core_clk);
			k++;
		end
		chk_bit("busy", 1'h0, flash_status[0]);
		chk_bit("latch", 1'h0, flash_status[1]);
	endtask : wait_idle

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		chk_byte("status", 8'h00, flash_status);
		chk_byte("config", 8'h07, flash_configuration);
		send(fsc_pkg::FSC_CMD_WRITE_REGS, 5'h10, 16'h3FD9, 1'h0);
		chk_bit("refused", 1'h1, refused);
		wregs(5'h0C, 16'h3FD9);
		chk_bit("refused", 1'h1, refused);
		wregs(5'h10, 16'h3FD9);
		chk_byte("status", 8'h3F, flash_status);
		chk_byte("config", 8'hD9, flash_configuration);
		wait_idle();
		chk_byte("status", 8'h3C, flash_status);
	endtask : t_regs
	task automatic t_array;
		for (int i = fsc_pkg::FSC_CMD_PAGE_PROGRAM; i <= fsc_pkg::FSC_CMD_CHIP_ERASE; i++) begin
			send(fsc_pkg::FSC_CMD_WRITE_ENABLE, 5'h00, 16'h0000, 1'h0);
			send(fsc_pkg::fsc_cmd_t'(i), 5'h00, 16'h0000, 1'h1);
			chk_bit("refused", 1'h1, refused);
		end
		send(fsc_pkg::FSC_CMD_CHIP_ERASE, 5'h00, 16'h0000, 1'h0);
		chk_bit("refused", 1'h1, refused);
		wregs(5'h08, 16'h0055);
		chk_byte("config", 8'hD9, flash_configuration);
		wait_idle();
		send(fsc_pkg::FSC_CMD_WRITE_ENABLE, 5'h00, 16'h0000, 1'h0);
		send(fsc_pkg::FSC_CMD_CHIP_ERASE, 5'h00, 16'h0000, 1'h0);
		chk_bit("start", 1'h1, op.start);
		chk_byte("cmd", 8'(fsc_pkg::FSC_CMD_CHIP_ERASE), 8'(op.cmd));
		chk_bit("busy", 1'h1, flash_status[0]);
		wait_idle();
		send(fsc_pkg::FSC_CMD_PAGE_PROGRAM, 5'h00, 16'h0000, 1'h0);
		chk_bit("refused", 1'h1, refused);
	endtask : t_array
	task automatic t_wide;
		send(fsc_pkg::FSC_CMD_ENTER_WIDE, 5'h00, 16'h0000, 1'h0);
		chk_byte("config", 8'hF9, flash_configuration);
		send(fsc_pkg::FSC_CMD_EXIT_WIDE, 5'h00, 16'h0000, 1'h0);
		chk_byte("config", 8'hD9, flash_configuration);
	endtask : t_wide
	// lock with the pin low, then the same with quad mode masking it
	task automatic t_hwprot;
		wregs(5'h08, 16'h8000);
		wait_idle();
		write_protect_n <= 1'h0;
		repeat (4) @(negedge core_clk);
		chk_bit("hw", 1'h1, hw_protect_state);
		wregs(5'h08, 16'h0000);
		chk_bit("refused", 1'h1, refused);
		chk_byte("status", 8'h80, {flash_status[7:2], 2'h0});
		write_protect_n <= 1'h1;
		repeat (4) @(negedge core_clk);
		wregs(5'h08, 16'hC000);
		wait_idle();
		write_protect_n <= 1'h0;
		repeat (4) @(negedge core_clk);
		chk_bit("hw", 1'h0, hw_protect_state);
		chk_bit("quad", 1'h1, quad_io_enable);
	endtask : t_hwprot
	// reset pin masked by quad mode, then acting, then a power-up reset mid-run
	task automatic t_pin;
		send(fsc_pkg::FSC_CMD_WRITE_ENABLE, 5'h00, 16'h0000, 1'h0);
		send(fsc_pkg::FSC_CMD_ENTER_WIDE, 5'h00, 16'h0000, 1'h0);
		hard_reset_n <= 1'h0;
		repeat (4) @(negedge core_clk);
		chk_bit("latch", 1'h1, flash_status[1]);
		chk_byte("config", 8'hF9, flash_configuration);
		hard_reset_n <= 1'h1;
		repeat (4) @(negedge core_clk);
		wregs(5'h10, 16'h0000);
		wait_idle();
		chk_byte("config", 8'h28, flash_configuration);
		send(fsc_pkg::FSC_CMD_WRITE_ENABLE, 5'h00, 16'h0000, 1'h0);
		hard_reset_n <= 1'h0;
		repeat (4) @(negedge core_clk);
		chk_byte("status", 8'h00, flash_status);
		chk_byte("config", 8'h0F, flash_configuration);
		hard_reset_n <= 1'h1;
		repeat (4) @(negedge core_clk);
		send(fsc_pkg::FSC_CMD_WRITE_ENABLE, 5'h00, 16'h0000, 1'h0);
		send(fsc_pkg::FSC_CMD_ENTER_WIDE, 5'h00, 16'h0000, 1'h0);
		chk_byte("config", 8'h2F, flash_configuration);
		rst_b <= 1'h0;
		repeat (3) @(negedge core_clk);
		rst_b <= 1'h1;
		chk_byte("status", 8'h00, flash_status);
		chk_byte("config", 8'h07, flash_configuration);
		send(fsc_pkg::FSC_CMD_WRITE_REGS, 5'h08, 16'h0000, 1'h0);
		chk_bit("refused", 1'h1, refused);
	endtask : t_pin

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	// ****************************************
	// clock, sequence, watchdog
	// ****************************************
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		fails = 0;
		checks_done = 0;
		rst_b = 1'h0;
		write_protect_n = 1'h1;
		hard_reset_n = 1'h1;
		req = '0;
		repeat (16) @(negedge core_clk);
		rst_b = 1'h1;
		t_regs();
		t_array();
		t_wide();
		t_hwprot();
		t_pin();
		report_and_stop();
	end
	// the scenarios need well under 1000 cycles
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
endmodule : flash_status_config_regs_test
